/* File: hdl/pms_pkg.sv */
// constants for the link status 2 and power management capability register bank
`default_nettype none
package pms_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register offsets, byte addresses
    localparam logic [7:0] LINK_STATUS_TWO_OFS = 8'h72;
    localparam logic [7:0] SLOT_CAPABILITIES_TWO_OFS = 8'h74;
    localparam logic [7:0] SLOT_CONTROL_TWO_OFS = 8'h78;
    localparam logic [7:0] SLOT_STATUS_TWO_OFS = 8'h7a;
    localparam logic [7:0] POWER_MGMT_CAPABILITIES_OFS = 8'hc0;
    localparam logic [7:0] CONFIG_LOCK_OFS = 8'hfc;
    // power management capability fields
    localparam int CAP_CODE_LSB = 0;
    localparam int CAP_CODE_W = 8;
    localparam logic [7:0] CAPABILITY_CODE = 8'h01;
    localparam int NEXT_PTR_LSB = 8;
    localparam int NEXT_PTR_W = 8;
    localparam int PM_VERSION_LSB = 16;
    localparam int PM_VERSION_W = 3;
    localparam logic [2:0] PM_SPEC_VERSION = 3'h3;
    localparam int DEV_INIT_BIT = 21;
    localparam logic DEV_INIT_RESET = 1'b0;
    localparam int AUX_CUR_LSB = 22;
    localparam int AUX_CUR_W = 3;
    localparam logic [2:0] AUX_CURRENT_NEED = 3'h0;
    localparam int D1_BIT = 25;
    localparam int D2_BIT = 26;
    localparam logic D1_SUPPORT = 1'b0;
    localparam logic D2_SUPPORT = 1'b0;
    localparam int PME_SUP_LSB = 27;
    localparam int PME_SUP_W = 5;
    localparam logic [4:0] PME_SUPPORT_RESET = 5'h19;
    // link status 2 and config lock fields
    localparam int DEEMPH_BIT = 0;
    localparam int LOCK_BIT = 0;
    // power states on the state input, and index of d3cold in pme support
    localparam logic [1:0] PM_D0 = 2'h0;
    localparam logic [1:0] PM_D1 = 2'h1;
    localparam logic [1:0] PM_D2 = 2'h2;
    localparam logic [1:0] PM_D3HOT = 2'h3;
    localparam int PME_D3COLD_IDX = 4;
endpackage
`default_nettype wire

/* File: hdl/pms_lock_field.sv */
// one lockable-write field with a constant reset value
`default_nettype none
module pms_lock_field #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_write,
    input wire logic i_lock,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic [WIDTH-1:0] o_value
);
    // writes take effect only while the lock is open
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_value <= RESET_VALUE;
        end else if (i_write && !i_lock) begin
            o_value <= i_wdata;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/pms_deemph_status.sv */
// tracks the present transmit de-emphasis level for link status 2
`default_nettype none
module pms_deemph_status (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_link_speed_5g,
    input wire logic i_tx_deemph_3p5,
    output logic o_current_deemph_level
);
    // at 5.0 gbps follow the transmitter: 0 is -6.0 db, 1 is -3.5 db
    // at 2.5 gt/s the bit has no meaning and reads 0
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_current_deemph_level <= 1'b0;
        end else if (i_link_speed_5g) begin
            o_current_deemph_level <= i_tx_deemph_3p5;
        end else begin
            o_current_deemph_level <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/pms_regs.sv */
// link status 2, slot 2 and power management capability register bank
//
// Summary of operation
// - at 5.0 gbps bit 0 of link status 2 shows de-emphasis, 1 is -3.5 db
// - at 2.5 gt/s the de-emphasis bit is meaningless; it reads zero here
// - slot capabilities 2, slot control 2 and slot status 2 read all zero
// - capability header bits 7:0 read 0x1, the power management id
// - bits 15:8 hold the next capability pointer, writable while unlocked
// - bits 18:16 read version 0x3
// - device specific init bit 21 resets to 0 and is writable while unlocked
// - aux current bits 24:22 read zero
// - d1 support bit 25 and d2 support bit 26 read zero
// - pme support bits 31:27 reset to 0b11001, writable while unlocked
// - pme is never forwarded in d3cold
// - writing pme support changes only the advertised value, not behaviour
//
// The implementer's own choice: the plain strobed port.
`default_nettype none
module pms_regs
    import pms_pkg::*;
#(
    parameter logic [7:0] NEXT_CAP_RESET = 8'hd0
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_link_speed_5g,
    input wire logic i_tx_deemph_3p5,
    input wire logic [1:0] i_pm_state,
    input wire logic i_d3cold,
    output logic o_pme_forward_ok,
    output logic [NEXT_PTR_W-1:0] o_next_cap_pointer,
    output logic o_device_specific_init,
    output logic [PME_SUP_W-1:0] o_pme_support_advertised,
    output logic o_lock_active
);

    logic lockable_write_access_closed;
    logic current_deemph_level;
    logic [NEXT_PTR_W-1:0] next_cap_pointer;
    logic device_specific_init;
    logic [PME_SUP_W-1:0] pme_support_adv;
    logic wr_power_mgmt_capabilities;
    logic wr_lock;
    logic [DATA_W-1:0] next_rdata;
    logic [PME_SUP_W-1:0] pme_actual;
    logic next_pme_ok;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    assign wr_power_mgmt_capabilities = i_write && hit(i_addr, POWER_MGMT_CAPABILITIES_OFS);
    assign wr_lock = i_write && hit(i_addr, CONFIG_LOCK_OFS);

    // lock for all lockable-write fields, opens at reset
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lockable_write_access_closed <= 1'b0;
        end else if (wr_lock) begin
            lockable_write_access_closed <= i_wdata[LOCK_BIT];
        end
    end

    pms_deemph_status u_deemph (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_link_speed_5g(i_link_speed_5g),
        .i_tx_deemph_3p5(i_tx_deemph_3p5),
        .o_current_deemph_level(current_deemph_level)
    );

    pms_lock_field #(.WIDTH(NEXT_PTR_W), .RESET_VALUE(NEXT_CAP_RESET)) u_next_ptr (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write(wr_power_mgmt_capabilities),
        .i_lock(lockable_write_access_closed),
        .i_wdata(i_wdata[NEXT_PTR_LSB +: NEXT_PTR_W]),
        .o_value(next_cap_pointer)
    );

    pms_lock_field #(.WIDTH(1), .RESET_VALUE(DEV_INIT_RESET)) u_dev_init (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write(wr_power_mgmt_capabilities),
        .i_lock(lockable_write_access_closed),
        .i_wdata(i_wdata[DEV_INIT_BIT]),
        .o_value(device_specific_init)
    );

    pms_lock_field #(.WIDTH(PME_SUP_W), .RESET_VALUE(PME_SUPPORT_RESET)) u_pme_sup (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write(wr_power_mgmt_capabilities),
        .i_lock(lockable_write_access_closed),
        .i_wdata(i_wdata[PME_SUP_LSB +: PME_SUP_W]),
        .o_value(pme_support_adv)
    );

    // read mux; unmapped and reserved bits read zero
    always_comb begin
        next_rdata = '0;
        if (i_read) begin
            unique case (1'b1)
                hit(i_addr, LINK_STATUS_TWO_OFS): begin
                    next_rdata[DEEMPH_BIT] = current_deemph_level;
                end
                hit(i_addr, SLOT_CAPABILITIES_TWO_OFS),
                hit(i_addr, SLOT_CONTROL_TWO_OFS),
                hit(i_addr, SLOT_STATUS_TWO_OFS): begin
                    next_rdata = '0;
                end
                hit(i_addr, POWER_MGMT_CAPABILITIES_OFS): begin
                    next_rdata[CAP_CODE_LSB +: CAP_CODE_W] = CAPABILITY_CODE;
                    next_rdata[NEXT_PTR_LSB +: NEXT_PTR_W] = next_cap_pointer;
                    next_rdata[PM_VERSION_LSB +: PM_VERSION_W] = PM_SPEC_VERSION;
                    next_rdata[DEV_INIT_BIT] = device_specific_init;
                    next_rdata[AUX_CUR_LSB +: AUX_CUR_W] = AUX_CURRENT_NEED;
                    next_rdata[D1_BIT] = D1_SUPPORT;
                    next_rdata[D2_BIT] = D2_SUPPORT;
                    next_rdata[PME_SUP_LSB +: PME_SUP_W] = pme_support_adv;
                end
                hit(i_addr, CONFIG_LOCK_OFS): begin
                    next_rdata[LOCK_BIT] = lockable_write_access_closed;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // real pme forwarding uses the fixed default set, not the advertised field
    assign pme_actual = PME_SUPPORT_RESET;
    always_comb begin
        next_pme_ok = 1'b0;
        if (!i_d3cold) begin
            unique case (i_pm_state)
                PM_D0: next_pme_ok = pme_actual[PM_D0];
                PM_D1: next_pme_ok = pme_actual[PM_D1];
                PM_D2: next_pme_ok = pme_actual[PM_D2];
                PM_D3HOT: next_pme_ok = pme_actual[PM_D3HOT];
            endcase
        end
        // d3cold bit of the set is never honoured here
        if (i_d3cold) begin
            next_pme_ok = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pme_forward_ok <= 1'b0;
        end else begin
            o_pme_forward_ok <= next_pme_ok;
        end
    end

    // registered copies of the writable fields for the rest of the port
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_next_cap_pointer <= NEXT_CAP_RESET;
        end else begin
            o_next_cap_pointer <= next_cap_pointer;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_device_specific_init <= DEV_INIT_RESET;
        end else begin
            o_device_specific_init <= device_specific_init;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pme_support_advertised <= PME_SUPPORT_RESET;
        end else begin
            o_pme_support_advertised <= pme_support_adv;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_lock_active <= 1'b0;
        end else begin
            o_lock_active <= lockable_write_access_closed;
        end
    end

endmodule
`default_nettype wire

/* File: dv/pms_regs_checker.sv */
// port assertions for the register bank
`default_nettype none
module pms_regs_checker (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic i_read,
    input wire logic [31:0] o_rdata,
    input wire logic i_link_speed_5g,
    input wire logic i_tx_deemph_3p5,
    input wire logic [1:0] i_pm_state,
    input wire logic i_d3cold,
    input wire logic o_pme_forward_ok
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    a_read_idle: assert property (!i_read |=> o_rdata == 32'h0)
        else $error("read data not zero when idle");
    a_cap_code: assert property (i_read && i_addr == 8'hc0 |=> o_rdata[7:0] == 8'h01)
        else $error("capability code wrong");
    a_pm_version: assert property (i_read && i_addr == 8'hc0 |=> o_rdata[20:16] == 5'h03)
        else $error("version field wrong");
    a_aux_d1d2: assert property (i_read && i_addr == 8'hc0 |=> o_rdata[26:22] == 5'h0)
        else $error("aux or d1 d2 field not zero");
    a_slot_zero: assert property (i_read && i_addr inside {8'h74, 8'h78, 8'h7a}
        |=> o_rdata == 32'h0)
        else $error("slot register not zero");
    a_deemph_bit: assert property (i_read && i_addr == 8'h72 && $stable(i_link_speed_5g)
        && $stable(i_tx_deemph_3p5)
        |=> o_rdata == {31'h0, $past(i_link_speed_5g & i_tx_deemph_3p5)})
        else $error("link status 2 wrong");
    a_unmapped_zero: assert property (i_read && !(i_addr inside {8'h72, 8'h74, 8'h78, 8'h7a,
        8'hc0, 8'hfc}) |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_no_d3cold: assert property (i_d3cold |=> !o_pme_forward_ok)
        else $error("pme forwarded in d3cold");
    a_pme_states: assert property (i_reset_n && !i_d3cold
        |=> o_pme_forward_ok == ($past(i_pm_state) inside {2'h0, 2'h3}))
        else $error("pme forwarding state wrong");
endmodule
bind pms_regs pms_regs_checker chk (.i_clock, .i_reset_n, .i_addr, .i_read, .o_rdata,
    .i_link_speed_5g, .i_tx_deemph_3p5, .i_pm_state, .i_d3cold, .o_pme_forward_ok);
`default_nettype wire

/* File: dv/pms_regs_tb.sv */
// testbench for the register bank
`default_nettype none
module pms_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] d;} pms_row_t;
    logic i_clock = 0, i_reset_n = 0, i_write = 0, i_read = 0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_link_speed_5g = 0, i_tx_deemph_3p5 = 0, i_d3cold = 0;
    logic [1:0] i_pm_state = 2'h0;
    logic [31:0] o_rdata;
    logic o_pme_forward_ok, o_device_specific_init, o_lock_active;
    logic [7:0] o_next_cap_pointer;
    logic [4:0] o_pme_support_advertised;
    int mismatches = 0, n_checks = 0;
    pms_row_t rows [7] = '{'{8'h72, 32'h0}, '{8'h74, 32'h0}, '{8'h78, 32'h0},
        '{8'h7a, 32'h0}, '{8'hc0, 32'hc803d001}, '{8'hfc, 32'h0}, '{8'h10, 32'h0}};
    always #20 i_clock = ~i_clock;
    pms_regs dut (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
        .i_link_speed_5g, .i_tx_deemph_3p5, .i_pm_state, .i_d3cold, .o_pme_forward_ok,
        .o_next_cap_pointer, .o_device_specific_init, .o_pme_support_advertised,
        .o_lock_active);
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_reset_n <= 1'b1;
        foreach (rows[k]) rd(rows[k].a, rows[k].d);
        chk({27'h0, o_pme_support_advertised}, 32'h19);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            wr(rows[k].a, 32'hffffffff);
            rd(rows[k].a, 32'h0);
        end
        $display("test read only writes done");
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clock);
            i_link_speed_5g <= k[1];
            i_tx_deemph_3p5 <= k[0];
            rd(8'h72, {31'h0, k[1] & k[0]});
        end
        $display("test deemphasis done");
        wr(8'hc0, 32'h00201200);
        rd(8'hc0, 32'h00231201);
        chk({24'h0, o_next_cap_pointer}, 32'h12);
        chk({31'h0, o_device_specific_init}, 32'h1);
        chk({27'h0, o_pme_support_advertised}, 32'h0);
        for (int k = 0; k < 5; k++) begin
            @(posedge i_clock);
            i_pm_state <= k[1:0];
            i_d3cold <= k[2];
            repeat (2) @(posedge i_clock);
            #1 chk({31'h0, o_pme_forward_ok}, {31'h0, k < 4 && k[0] == k[1]});
        end
        $display("test pme forwarding done");
        wr(8'hfc, 32'h1);
        rd(8'hfc, 32'h1);
        chk({31'h0, o_lock_active}, 32'h1);
        wr(8'hc0, 32'hffffffff);
        rd(8'hc0, 32'h00231201);
        $display("test lock done");
        @(posedge i_clock);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_reset_n <= 1'b1;
        rd(8'hc0, 32'hc803d001);
        rd(8'hfc, 32'h0);
        $display("test second reset done");
        wr(8'hc0, 32'hffffffff);
        rd(8'hc0, 32'hf823ff01);
        chk({27'h0, o_pme_support_advertised}, 32'h1f);
        @(posedge i_clock);
        i_d3cold <= 1'b0;
        i_pm_state <= 2'h1;
        repeat (2) @(posedge i_clock);
        #1 chk({31'h0, o_pme_forward_ok}, 32'h0);
        $display("test advertised pme done");
        wrap_up();
    end
endmodule
`default_nettype wire
